/* verilog/rbc_core.sv */
module rbc_core #(
  parameter int RST_EXIT_CYCLES = rbc_pkg::RST_EXIT_CYC,
  parameter int INIT_CYCLES     = rbc_pkg::INIT_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       digitalSupplyGood,
  input  wire logic                       resetPin_b,
  input  wire logic                       watchdogKickInput,
  input  wire logic [23:0]                watchdogLimit,
  input  wire logic [6:0]                 detectedAddr,
  input  wire logic                       flashBlank,
  input  wire logic                       fwChecksumOk,
  input  wire logic                       cfgChecksumOk,
  input  wire logic                       logChecksumOk,
  input  wire logic                       paramWrite,
  input  wire logic [rbc_pkg::ADDR_W-1:0] paramAddr,
  input  wire logic [rbc_pkg::PARAM_W-1:0] paramData,
  input  wire logic [rbc_pkg::PARAM_W-1:0] paramMin,
  input  wire logic [rbc_pkg::PARAM_W-1:0] paramMax,
  input  wire logic                       commitCmd,
  input  wire logic                       liveUpdateStart,
  input  wire logic [rbc_pkg::DATA_W-1:0] flashRdData,
  input  wire logic [rbc_pkg::ECC_W-1:0]  flashRdEcc,
  input  wire logic [rbc_pkg::DATA_W-1:0] flashWrData,
  output logic                            coreRunning,
  output logic                            inInit,
  output logic                            fwBlocked,
  output logic                            useFactoryCfg,
  output logic                            bus_alert_out,
  output logic                            cfgCrcFlag,
  output logic                            logIntact,
  output logic                            tapEnable,
  output logic                            sysClkEnable,
  output logic [rbc_pkg::FAST_PWM_PIN_N-1:0]      fast_pwm_pin,
  output logic [rbc_pkg::FAST_PWM_PIN_N-1:0]      fast_pwm_pin_oe,
  output logic [rbc_pkg::GPIO_N-1:0]      gpioOe,
  output logic                            paramAccepted,
  output logic                            paramRejected,
  output logic                            commitPulse,
  output logic                            loggingEnabled,
  output logic [rbc_pkg::ECC_W-1:0]       flashWrEcc,
  output logic [rbc_pkg::DATA_W-1:0]      flashCorrData,
  output logic                            flashDblErr
);

  rbc_pkg::rbc_state_t stateReg, stateNext;
  logic [rbc_pkg::CNT_W-1:0] cntReg;
  logic [23:0]               wdReg;
  logic                      kickReg;
  logic                      firstBootReg;
  logic [rbc_pkg::PARAM_W-1:0] cfgRam [rbc_pkg::CFG_DEPTH];
  logic [3:0]                slowCntReg;

  // supply, pin and watchdog reset sources collapse into one internal request
  wire logic kickEdge   = watchdogKickInput ^ kickReg;
  wire logic wdExpire   = (stateReg == rbc_pkg::RBC_RUN) && (wdReg >= watchdogLimit) &&
                          (watchdogLimit != 24'h000000);                 // see RULE_15
  wire logic holdReset  = !digitalSupplyGood || !resetPin_b || wdExpire; // see RULE_01 RULE_02 RULE_23
  wire logic exitDone   = cntReg >= (rbc_pkg::CNT_W)'(RST_EXIT_CYCLES - 1); // see RULE_03
  wire logic initDone   = cntReg >= (rbc_pkg::CNT_W)'(INIT_CYCLES - 1);     // see RULE_04
  wire logic inRange    = (paramData >= paramMin) && (paramData <= paramMax); // see RULE_17
  wire logic tapCond    = flashBlank || (detectedAddr == rbc_pkg::JTAG_ADDR); // see RULE_07 RULE_08

  // state sequencing: reset, init, then run or halt on bad firmware
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      rbc_pkg::RBC_RESET: if (exitDone) stateNext = rbc_pkg::RBC_INIT;
      rbc_pkg::RBC_INIT:  if (initDone) begin
        stateNext = fwChecksumOk ? rbc_pkg::RBC_RUN : rbc_pkg::RBC_HALT; // see RULE_11
      end
      rbc_pkg::RBC_RUN:   stateNext = rbc_pkg::RBC_RUN;
      rbc_pkg::RBC_HALT:  stateNext = rbc_pkg::RBC_HALT;
      default:            stateNext = rbc_pkg::RBC_RESET;
    endcase
    if (holdReset) stateNext = rbc_pkg::RBC_RESET; // see RULE_02 RULE_23
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= rbc_pkg::RBC_RESET;
      cntReg   <= '0;
    end else begin
      stateReg <= stateNext;
      cntReg   <= (stateNext != stateReg || holdReset) ? '0 : cntReg + 1'b1;
    end
  end

  // watchdog counts only while firmware runs; a kick is any edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdReg   <= '0;
      kickReg <= 1'b0;
    end else begin
      kickReg <= watchdogKickInput;
      wdReg   <= (stateReg != rbc_pkg::RBC_RUN || kickEdge) ? 24'h000000 : wdReg + 1'b1;
    end
  end

  // power-up only decisions, plus the log check at every init end; a watchdog or pin reset is not a power-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstBootReg   <= 1'b1;
      tapEnable      <= 1'b0; // see RULE_06
      useFactoryCfg  <= 1'b0;
      cfgCrcFlag     <= 1'b0;
      bus_alert_out  <= 1'b0;
      logIntact      <= 1'b0;
      loggingEnabled <= 1'b0;
    end else begin
      if (!digitalSupplyGood) begin
        firstBootReg <= 1'b1;
      end else if (stateReg == rbc_pkg::RBC_INIT && initDone && firstBootReg) begin
        firstBootReg  <= 1'b0;
        tapEnable     <= tapCond;         // see RULE_07 RULE_08 RULE_10
        useFactoryCfg <= !cfgChecksumOk;  // see RULE_12 RULE_21
        cfgCrcFlag    <= !cfgChecksumOk;  // see RULE_13
        bus_alert_out <= !cfgChecksumOk;  // see RULE_13
      end
      if (stateReg == rbc_pkg::RBC_INIT && initDone) begin
        logIntact      <= logChecksumOk;  // see RULE_14
        loggingEnabled <= logChecksumOk;
      end else if (liveUpdateStart) begin
        loggingEnabled <= 1'b0;           // see RULE_22
      end
    end
  end

  // pin states: outputs idle in reset and init; limitation: no pwm engine here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_pwm_pin    <= '0;
      fast_pwm_pin_oe <= '1;
      gpioOe          <= '0;
      coreRunning     <= 1'b0;
      inInit          <= 1'b0;
      fwBlocked       <= 1'b0;
    end else begin
      fast_pwm_pin    <= '0;              // see RULE_05 RULE_16 RULE_21
      fast_pwm_pin_oe <= '1;              // see RULE_05 RULE_16
      gpioOe          <= '0;              // see RULE_05 RULE_16 RULE_21
      coreRunning     <= stateNext == rbc_pkg::RBC_RUN;
      inInit          <= stateNext == rbc_pkg::RBC_INIT;
      fwBlocked       <= stateNext == rbc_pkg::RBC_HALT; // see RULE_11
    end
  end

  // clock slowdown: drop one enable in ten while the test port is on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slowCntReg   <= '0;
      sysClkEnable <= 1'b1;
    end else begin
      slowCntReg   <= (slowCntReg == rbc_pkg::CLK_SLOW_DEN - 4'h1) ? 4'h0 : slowCntReg + 4'h1;
      sysClkEnable <= !(tapEnable && slowCntReg == 4'h0); // see RULE_09
    end
  end

  // parameter writes reach only the ram copy; commit is a separate strobe
  always_ff @(posedge clk) begin
    if (paramWrite && inRange && stateReg != rbc_pkg::RBC_RESET) begin
      cfgRam[paramAddr] <= paramData;     // see RULE_20
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      paramAccepted <= 1'b0;
      paramRejected <= 1'b0;
      commitPulse   <= 1'b0;
    end else begin
      paramAccepted <= paramWrite && inRange;   // see RULE_17
      paramRejected <= paramWrite && !inRange;  // see RULE_17
      commitPulse   <= commitCmd;               // see RULE_20
    end
  end

  // hamming(38,32): check bit b sits at position 2^b, data bits fill the other slots
  // codeword position of data bit i: the i-th slot from 3 to 38 that is no power of two
  function automatic logic [5:0] dataPos(input int i);
    int         n;
    logic [5:0] p;
    n = 0;
    p = 6'h00;
    for (int k = 3; k < 39; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == i) p = 6'(k);
        n++;
      end
    end
    return p;
  endfunction

  // check bit b is the parity of every data bit whose position code has bit b set
  function automatic logic [5:0] eccGen(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) c = c ^ dataPos(i);
    end
    return c;
  endfunction

  // the syndrome names the flipped position; a check-bit flip leaves the data alone
  wire logic [5:0] rdSyn   = eccGen(flashRdData) ^ flashRdEcc;
  logic [31:0]     flipMask;

  // one flip per bit position, selected by the syndrome
  for (genvar g = 0; g < 32; g++) begin : gFlip
    assign flipMask[g] = (rdSyn == dataPos(g)); // see RULE_19
  end

  // limitation: six bits give single correction only, so a double flip may alias
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flashWrEcc    <= '0;
      flashCorrData <= '0;
      flashDblErr   <= 1'b0;
    end else begin
      flashWrEcc    <= eccGen(flashWrData);          // see RULE_18
      flashCorrData <= flashRdData ^ flipMask;       // see RULE_19
      flashDblErr   <= rdSyn > 6'h26;                // syndrome beyond the last position
    end
  end

  // checks
  property p_holdReset;
    @(posedge clk) disable iff (!rst_b) !resetPin_b |=> stateReg == rbc_pkg::RBC_RESET;
  endproperty
  a_holdReset: assert property (p_holdReset) else $error("pin low left reset"); // see RULE_02

  property p_pwmLow;
    @(posedge clk) disable iff (!rst_b) inInit |-> fast_pwm_pin == '0 && gpioOe == '0;
  endproperty
  a_pwmLow: assert property (p_pwmLow) else $error("pins active in init"); // see RULE_05

  property p_wdReset;
    @(posedge clk) disable iff (!rst_b) wdExpire |=> stateReg == rbc_pkg::RBC_RESET;
  endproperty
  a_wdReset: assert property (p_wdReset) else $error("watchdog no reset"); // see RULE_15

  property p_halt;
    @(posedge clk) disable iff (!rst_b) fwBlocked |-> !coreRunning;
  endproperty
  a_halt: assert property (p_halt) else $error("firmware ran while blocked"); // see RULE_11

  property p_alert;
    @(posedge clk) disable iff (!rst_b) $rose(cfgCrcFlag) |-> bus_alert_out && useFactoryCfg;
  endproperty
  a_alert: assert property (p_alert) else $error("crc flag without alert"); // see RULE_13

  property p_range;
    @(posedge clk) disable iff (!rst_b) paramWrite && !inRange |=> paramRejected && !paramAccepted;
  endproperty
  a_range: assert property (p_range) else $error("bad parameter accepted"); // see RULE_17

  property p_ecc;
    @(posedge clk) disable iff (!rst_b)
      rdSyn == 6'h00 |=> flashCorrData == $past(flashRdData);
  endproperty
  a_ecc: assert property (p_ecc) else $error("clean word altered"); // see RULE_19

  property p_initStart;
    @(posedge clk) disable iff (!rst_b)
      stateReg == rbc_pkg::RBC_RESET && !holdReset && exitDone |=> stateReg == rbc_pkg::RBC_INIT;
  endproperty
  a_initStart: assert property (p_initStart) else $error("init not entered"); // see RULE_03 RULE_04

  property p_supplyReset;
    @(posedge clk) disable iff (!rst_b) !digitalSupplyGood |=> stateReg == rbc_pkg::RBC_RESET;
  endproperty
  a_supplyReset: assert property (p_supplyReset) else $error("supply low left reset"); // see RULE_01

  property p_parkPins;
    @(posedge clk) disable iff (!rst_b)
      stateReg == rbc_pkg::RBC_RESET |=> fast_pwm_pin == '0 && fast_pwm_pin_oe == '1 && gpioOe == '0;
  endproperty
  a_parkPins: assert property (p_parkPins) else $error("pins active in reset"); // see RULE_16

  property p_kick;
    @(posedge clk) disable iff (!rst_b) kickEdge |=> wdReg == 24'h000000;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not clear watchdog"); // see RULE_15

  property p_tapHold;
    @(posedge clk) disable iff (!rst_b)
      $changed(tapEnable) |-> $past(stateReg) == rbc_pkg::RBC_INIT && $past(initDone);
  endproperty
  a_tapHold: assert property (p_tapHold) else $error("test port moved outside init end"); // see RULE_06

  property p_slowOff;
    @(posedge clk) disable iff (!rst_b) !tapEnable |=> sysClkEnable;
  endproperty
  a_slowOff: assert property (p_slowOff) else $error("clock slowed without test port"); // see RULE_09

  property p_accept;
    @(posedge clk) disable iff (!rst_b) paramWrite && inRange |=> paramAccepted && !paramRejected;
  endproperty
  a_accept: assert property (p_accept) else $error("good parameter refused"); // see RULE_17

  property p_ramWrite;
    @(posedge clk) disable iff (!rst_b)
      paramWrite && inRange && stateReg != rbc_pkg::RBC_RESET |=>
        cfgRam[$past(paramAddr)] == $past(paramData);
  endproperty
  a_ramWrite: assert property (p_ramWrite) else $error("ram copy not updated"); // see RULE_20

  property p_commit;
    @(posedge clk) disable iff (!rst_b) commitCmd |=> commitPulse;
  endproperty
  a_commit: assert property (p_commit) else $error("commit strobe lost"); // see RULE_20

  property p_logOff;
    @(posedge clk) disable iff (!rst_b)
      liveUpdateStart && !(stateReg == rbc_pkg::RBC_INIT && initDone) |=> !loggingEnabled;
  endproperty
  a_logOff: assert property (p_logOff) else $error("logging left on in update"); // see RULE_22

endmodule

/* verilog/rbc_pkg.sv */
// Summary of operation
// (RULE_01) supply-good detector releases internal reset once the supply is up
// (RULE_02) low reset pin holds the device in reset while held
// (RULE_03) reset state ends within 1 ms after the pin rises
// (RULE_04) every reset exit runs a 20 ms initialization, then normal operation
// (RULE_05) during init fast pwm pins low, other gpio pins undriven
// (RULE_06) test port disabled by default, its four pins act as gpio
// (RULE_07) blank configuration flash at power-up enables the test port
// (RULE_08) detected bus address 126 at power-up enables the test port
// (RULE_09) system clock runs at ninety percent while test port enabled
// (RULE_10) test port follows standard tap protocol, no boundary scan
// (RULE_11) firmware checksum mismatch blocks firmware, only bus commands wait
// (RULE_12) configuration checksum mismatch loads factory defaults
// (RULE_13) configuration mismatch raises bus alert and a status flag
// (RULE_14) error-log checksum decides whether log contents are intact
// (RULE_15) firmware watchdog expiry triggers a normal device reset
// (RULE_16) in reset gpio pins open-drain, fast pwm pins driven low
// (RULE_17) each received parameter is range checked before acceptance
// (RULE_18) flash writes store six check bits per 32-bit word
// (RULE_19) flash reads correct any single-bit error
// (RULE_20) parameter writes change ram copy only; commit command stores flash
// (RULE_21) factory config: outputs hi-z, fast pwm low, no sequencing
// (RULE_22) live update: unprotect, erase, write, reset; old config, no logging
// (RULE_23) power-on, pin and watchdog resets share one reset and init path
package rbc_pkg;
  localparam int  CLK_MHZ        = 250;
  localparam int  RST_EXIT_US    = 1000;
  localparam int  INIT_MS        = 20;
  localparam int  RST_EXIT_CYC   = RST_EXIT_US * CLK_MHZ / 2;
  localparam int  INIT_CYC       = INIT_MS * 1000 * CLK_MHZ;
  localparam int  CNT_W          = 24;
  localparam logic [6:0] JTAG_ADDR = 7'h7e;
  localparam int  GPIO_N         = 16;
  localparam int  FAST_PWM_PIN_N         = 8;
  localparam int  DATA_W         = 32;
  localparam int  ECC_W          = 6;
  localparam int  PARAM_W        = 16;
  localparam int  CFG_DEPTH      = 16;
  localparam int  ADDR_W         = 4;
  localparam logic [3:0] CLK_SLOW_DEN = 4'ha; // skip one of every ten cycles
  typedef enum logic [1:0] {
    RBC_RESET = 2'b00,
    RBC_INIT  = 2'b01,
    RBC_RUN   = 2'b10,
    RBC_HALT  = 2'b11
  } rbc_state_t;
endpackage

/* testbench/rbc_host_model.sv */
module rbc_host_model (
  input  wire logic                         clk,
  output logic                              paramWrite,
  output logic [rbc_pkg::ADDR_W-1:0]        paramAddr,
  output logic [rbc_pkg::PARAM_W-1:0]       paramData,
  output logic [rbc_pkg::PARAM_W-1:0]       paramMin,
  output logic [rbc_pkg::PARAM_W-1:0]       paramMax,
  output logic                              commitCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    paramWrite = 1'b0;
    commitCmd  = 1'b0;
    paramAddr  = 4'h0;
    paramData  = 16'h0000;
    paramMin   = 16'h0000;
    paramMax   = 16'hffff;
  end
  // one parameter write; released data shows the inverse so stale bits never look valid
  task put(input logic [3:0] a, input logic [15:0] d, lo, hi);
    @(posedge clk);
    paramWrite <= 1'b1;
    paramAddr  <= a;
    paramData  <= d;
    paramMin   <= lo;
    paramMax   <= hi;
    @(posedge clk);
    paramWrite <= 1'b0;
    paramData  <= ~d;
  endtask
  // the ram copy only becomes nonvolatile through this command
  task commit();
    @(posedge clk);
    commitCmd <= 1'b1;
    @(posedge clk);
    commitCmd <= 1'b0;
  endtask
endmodule

/* testbench/reset_boot_config_integrity_tb_top.sv */
module reset_boot_config_integrity_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, supGood, pin_b, kick, fBlank, fwOk, cfgOk, logOk, upd;
  logic [23:0] wdLim;
  logic [6:0]  addr;
  logic [31:0] rdD, wrD, corr;
  logic [5:0]  rdE, wrE;
  logic        pW, cmd, run, init, fwBlk, fact, alert, crcF, logI, tap, sysEn;
  logic        acc, rej, cmt, logEn, dbl;
  logic [3:0]  pA;
  logic [15:0] pD, pLo, pHi, gOe;
  logic [7:0]  pwm, pwmOe;
  int          miscompares, n_tests;

  rbc_core #(.RST_EXIT_CYCLES(8), .INIT_CYCLES(20)) i_rbc_core (.clk(clk), .rst_b(rst_b),
    .digitalSupplyGood(supGood), .resetPin_b(pin_b), .watchdogKickInput(kick),
    .watchdogLimit(wdLim), .detectedAddr(addr), .flashBlank(fBlank), .fwChecksumOk(fwOk),
    .cfgChecksumOk(cfgOk), .logChecksumOk(logOk), .paramWrite(pW), .paramAddr(pA),
    .paramData(pD), .paramMin(pLo), .paramMax(pHi), .commitCmd(cmd),
    .liveUpdateStart(upd), .flashRdData(rdD), .flashRdEcc(rdE), .flashWrData(wrD),
    .coreRunning(run), .inInit(init), .fwBlocked(fwBlk), .useFactoryCfg(fact),
    .bus_alert_out(alert), .cfgCrcFlag(crcF), .logIntact(logI), .tapEnable(tap),
    .sysClkEnable(sysEn), .fast_pwm_pin(pwm), .fast_pwm_pin_oe(pwmOe), .gpioOe(gOe),
    .paramAccepted(acc), .paramRejected(rej), .commitPulse(cmt), .loggingEnabled(logEn),
    .flashWrEcc(wrE), .flashCorrData(corr), .flashDblErr(dbl));
  rbc_host_model i_rbc_host_model (.clk(clk), .paramWrite(pW), .paramAddr(pA),
    .paramData(pD), .paramMin(pLo), .paramMax(pHi), .commitCmd(cmd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait: sel 0 for init, 1 for end of init
  task wt(input bit sel, input int lim);
    int k;
    k = 0;
    while ((sel ? (run | fwBlk) : init) !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    n_tests++;
    if (k >= lim) begin
      miscompares++;
      $display("MISMATCH t=%0t waited=%h limit=%h", $time, k, lim);
      close_out();
    end
  endtask
  // pins parked: fast pwm low and driven, gpio undriven
  task pins();
    chk(pwm, 8'h00);
    chk(pwmOe, 8'hff);
    chk(gOe, 16'h0000);
  endtask
  // supply cycle with given strap and checksum levels
  task boot(input logic fw, cfg, blank, input logic [6:0] a);
    @(posedge clk);
    supGood <= 1'b0;
    fwOk <= fw;
    cfgOk <= cfg;
    fBlank <= blank;
    addr <= a;
    repeat (3) @(posedge clk);
    #1;
    pins();
    @(posedge clk);
    supGood <= 1'b1;
    wt(0, 10);
    pins();
    wt(1, 22);
  endtask

  task t_first_boot();
    pins();
    @(posedge clk);
    rst_b <= 1'b1;
    supGood <= 1'b1;
    wt(0, 10);
    pins();
    wt(1, 22);
    chk({fwBlk, fact, alert, crcF, logI, tap}, 6'h1d);
    t_slow(1);
  endtask
  // count dropped clock enables over ten cycles
  task t_slow(input int exp);
    int lows;
    lows = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      lows += (sysEn === 1'b0);
    end
    chk(lows, exp);
  endtask
  task t_params();
    i_rbc_host_model.put(4'h3, 16'h0050, 16'h0010, 16'h0100);
    #1 chk({acc, rej}, 2'b10);
    i_rbc_host_model.put(4'h4, 16'h0101, 16'h0010, 16'h0100);
    #1 chk({acc, rej}, 2'b01);
    i_rbc_host_model.put(4'h5, 16'h0100, 16'h0010, 16'h0100);
    #1 chk({acc, rej}, 2'b10);
    i_rbc_host_model.commit();
    #1 chk(cmt, 1'b1);
  endtask
  // read back what was written with one data or check bit flipped per pass
  task t_ecc(input int b, input bit onCheck);
    logic [5:0] e;
    @(posedge clk);
    wrD <= 32'hc3a5_0f96 ^ b;
    repeat (2) @(posedge clk);
    #1;
    e = wrE;
    @(posedge clk);
    rdD <= onCheck ? wrD : wrD ^ (32'h1 << b);
    rdE <= onCheck ? e ^ (6'h01 << (b % 6)) : e;
    repeat (2) @(posedge clk);
    #1;
    chk(corr, wrD);
    chk(dbl, 1'b0);
  endtask
  // kicks hold the watchdog off; once they stop it resets the device
  task t_resets();
    @(posedge clk);
    kick <= ~kick;
    logOk <= 1'b1;
    @(posedge clk);
    wdLim <= 24'd30;
    repeat (4) begin
      repeat (10) @(posedge clk);
      kick <= ~kick;
    end
    #1 chk(run, 1'b1);
    wt(0, 200);
    @(posedge clk);
    wdLim <= 24'd0;
    wt(1, 22);
    chk({logI, logEn}, 2'b11);
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    #1 chk({run, logEn}, 2'b10);
    @(posedge clk);
    pin_b <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({run, init}, 2'b00);
    @(posedge clk);
    pin_b <= 1'b1;
    wt(0, 10);
    wt(1, 22);
    chk(tap, 1'b1);
  endtask

  initial begin
    {rst_b, supGood, kick, upd, fwOk, fBlank, cfgOk, logOk} = 8'b0000_1000;
    {pin_b, wdLim, addr, rdD, rdE, wrD} = {1'b1, 24'h0, 7'h7e, 32'h0, 6'h0, 32'h0};
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1;
    t_first_boot();
    t_params();
    for (int b = 0; b < 32; b += 13) t_ecc(b, 1'b0);
    t_ecc(31, 1'b0);
    for (int b = 0; b < 6; b += 5) t_ecc(b, 1'b1);
    t_resets();
    boot(1'b0, 1'b1, 1'b1, 7'h20);
    chk({fwBlk, fact, tap}, 3'b101);
    boot(1'b1, 1'b1, 1'b0, 7'h20);
    chk({run, fact, alert, tap}, 4'b1000);
    t_slow(0);
    close_out();
  end
endmodule
